//--- common/csda_pkg.sv
// Purpose: Shared constants for the CPU state and data access block
// Assumes: APB register map, 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses on the APB side
package csda_pkg;

  // Register offsets
  localparam logic [7:0] OFF_ACC_HIGH  = 8'h00;
  localparam logic [7:0] OFF_ACC_LOW   = 8'h04;
  localparam logic [7:0] OFF_EXT_CTRL  = 8'h08;
  localparam logic [7:0] OFF_COND_CODE = 8'h0c;
  localparam logic [7:0] OFF_STACK_PTR = 8'h10;
  localparam logic [7:0] OFF_PROG_CNT  = 8'h14;
  localparam logic [7:0] OFF_STATUS    = 8'h18;
  localparam logic [7:0] OFF_XFER_ADDR = 8'h1c;
  localparam logic [7:0] OFF_XFER_DATA = 8'h20;
  localparam logic [7:0] OFF_XFER_CMD  = 8'h24;
  localparam logic [7:0] OFF_OP_CTRL   = 8'h28;
  localparam logic [7:0] OFF_OP_RESULT = 8'h2c;
  localparam logic [7:0] OFF_INFO      = 8'h30;

  // Accumulator layout
  localparam int ACC_HIGH_BITS = 10;

  // Extended control register fields and reset values
  localparam int         EXT_TRACE_POS   = 7;
  localparam int         EXT_RSVD_LSB    = 3;
  localparam logic [3:0] EXT_RSVD_VALUE  = 4'hf;
  localparam int         EXT_MASK_LSB    = 0;
  localparam logic       TRACE_RESET     = 1'h0;
  localparam logic [2:0] MASK_RESET      = 3'h7;

  // Condition code fields and reset value
  localparam int         COND_I_POS      = 7;
  localparam int         COND_H_POS      = 5;
  localparam int         COND_Z_POS      = 2;
  localparam int         COND_C_POS      = 0;
  localparam logic [7:0] COND_RESET      = 8'h80;

  // Access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  // Transfer command fields
  localparam int         CMD_SIZE_LSB  = 0;
  localparam int         CMD_WRITE_POS = 2;
  localparam int         CMD_STACK_LSB = 4;
  localparam logic [1:0] STACK_NONE    = 2'h0;
  localparam logic [1:0] STACK_PUSH    = 2'h1;
  localparam logic [1:0] STACK_POP     = 2'h2;

  // Status fields
  localparam int STAT_BOOT_DONE = 0;
  localparam int STAT_BUSY      = 1;
  localparam int STAT_ERR_ALIGN = 2;
  localparam int STAT_ERR_OP    = 3;

  // Operation control fields
  localparam int OPC_CODE_LSB = 0;
  localparam int OPC_BIT_LSB  = 8;
  localparam int OPC_DATA_LSB = 16;

  // Instruction inventory figures
  localparam logic [7:0] TYPES_TOTAL = 8'h57;
  localparam logic [7:0] TYPES_ARITH = 8'h1b;
  localparam logic [7:0] TYPES_SHIFT = 8'h08;

  typedef enum logic [2:0] {
    OP_BIT_SET,
    OP_BIT_CLR,
    OP_BIT_NOT,
    OP_BIT_TST,
    OP_DEC_ADD,
    OP_DEC_SUB,
    OP_PSYNC_LOAD,
    OP_PSYNC_STORE
  } csda_op_t;

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT
  } csda_state_t;

endpackage

//--- rtl/csda_access_split.sv
// Purpose: Splits one word or longword access into aligned bus pieces
// Assumes: Pieces are issued lowest address first
// Notes:   Purely combinational
`timescale 1ns/1ps
module csda_access_split (
  // Access description
  input  wire logic [1:0] startLow,
  input  wire logic [1:0] accSize,
  input  wire logic [1:0] pieceIdx,
  // Piece description
  output logic      [1:0] pieceSize,
  output logic      [1:0] pieceOff,
  output logic      [1:0] pieceCnt
);
  import csda_pkg::*;

  always_comb begin
    pieceSize = accSize;
    pieceOff  = 2'h0;
    pieceCnt  = 2'h1;
    if (accSize == SIZE_WORD && startLow[0]) begin
      pieceCnt  = 2'h2;
      pieceSize = SIZE_BYTE;
      pieceOff  = pieceIdx;
    end else if (accSize == SIZE_LONG && startLow[0]) begin
      pieceCnt = 2'h3;
      case (pieceIdx)
        2'h0: begin
          pieceSize = SIZE_BYTE;
          pieceOff  = 2'h0;
        end
        2'h1: begin
          pieceSize = SIZE_WORD;
          pieceOff  = 2'h1;
        end
        default: begin
          pieceSize = SIZE_BYTE;
          pieceOff  = 2'h3;
        end
      endcase
    end else if (accSize == SIZE_LONG && startLow[1]) begin
      pieceCnt  = 2'h2;
      pieceSize = SIZE_WORD;
      pieceOff  = pieceIdx[0] ? 2'h2 : 2'h0;
    end
  end

endmodule

//--- rtl/csda_op_unit.sv
// Purpose: Bit manipulation and decimal adjust on a byte operand
// Assumes: Flags come from the condition code register
// Notes:   Purely combinational
`timescale 1ns/1ps
module csda_op_unit (
  // Operation
  input  wire csda_pkg::csda_op_t opCode,
  input  wire logic [2:0]         bitSel,
  input  wire logic [7:0]         operand,
  input  wire logic               carryIn,
  input  wire logic               halfIn,
  // Result
  output logic      [7:0]         result,
  output logic                    zeroOut,
  output logic                    carryOut,
  output logic                    updZero,
  output logic                    updCarry,
  output logic                    invalidOp
);
  import csda_pkg::*;

  logic [7:0] corr;
  logic       adjLow;
  logic       adjHigh;

  always_comb begin
    result    = operand;
    zeroOut   = 1'b0;
    carryOut  = carryIn;
    updZero   = 1'b0;
    updCarry  = 1'b0;
    invalidOp = 1'b0;
    corr      = 8'h00;
    adjLow    = halfIn || (operand[3:0] > 4'h9);
    adjHigh   = carryIn || (operand > 8'h99);
    case (opCode)
      OP_BIT_SET: result[bitSel] = 1'b1;
      OP_BIT_CLR: result[bitSel] = 1'b0;
      OP_BIT_NOT: result[bitSel] = ~operand[bitSel];
      OP_BIT_TST: begin
        zeroOut = ~operand[bitSel];
        updZero = 1'b1;
      end
      OP_DEC_ADD: begin
        corr     = {adjHigh ? 4'h6 : 4'h0, adjLow ? 4'h6 : 4'h0};
        result   = operand + corr;
        carryOut = adjHigh;
        zeroOut  = (result == 8'h00);
        updZero  = 1'b1;
        updCarry = 1'b1;
      end
      OP_DEC_SUB: begin
        corr     = {carryIn ? 4'h6 : 4'h0, halfIn ? 4'h6 : 4'h0};
        result   = operand - corr;
        zeroOut  = (result == 8'h00);
        updZero  = 1'b1;
        updCarry = 1'b1;
      end
      default: invalidOp = 1'b1;
    endcase
  end

endmodule

//--- rtl/csda_core.sv
// Purpose: CPU architectural state and data access engine behind APB
// Assumes: Memory bus on ref_clk, right-justified piece data, big-endian
// Notes:   Stack, accumulator and flag contents carry no promise after reset
//
// How it works
// - Accumulator is 42 bits, read as two 32-bit halves
// - High half keeps 10 bits, rest sign-extended
// - Reset fetches start vector into program counter
// - Reset clears trace, sets all three interrupt mask bits
// - Other flags, accumulator, stack pointer not promised
// - Handles bit, decimal, byte, word, longword data
// - Bit operations select bit 0 to 7
// - Decimal adjust treats byte as two digits
// - Misaligned word or longword splits into accesses
// - Odd longword goes byte, word, byte
// - Decoder inventory totals 87 instruction types
// - Arithmetic class holds 27 instruction types
// - Shift class holds 8 instruction types
// - Pop is post-increment load, push pre-decrement
// - Peripheral-synchronised byte moves are not implemented
// - Trace bit raises trace event per operation
// - Three mask bits give level 0 to 7
`timescale 1ns/1ps
module csda_core #(
  parameter logic [31:0] VECTOR_ADDR = 32'h00000000
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory and peripheral bus
  output logic             memReq,
  output logic      [31:0] memAddr,
  output logic      [1:0]  memSize,
  output logic             memWrite,
  output logic      [31:0] memWdata,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata,
  // Core status
  output logic             traceExc,
  output logic      [2:0]  intMaskLevel
);
  import csda_pkg::*;

  typedef struct packed {
    csda_state_t                state;
    logic [ACC_HIGH_BITS-1:0]   accHigh;
    logic [31:0]                accLow;
    logic                       trace;
    logic [2:0]                 mask;
    logic [7:0]                 cond;
    logic [31:0]                sp;
    logic [31:0]                pc;
    logic [31:0]                xAddr;
    logic [31:0]                xData;
    logic [1:0]                 xSize;
    logic                       xWrite;
    logic [1:0]                 xStack;
    logic [1:0]                 pieceIdx;
    logic [31:0]                asm;
    logic [7:0]                 opResult;
    logic                       bootDone;
    logic                       errAlign;
    logic                       errOp;
    logic                       memReq;
    logic [31:0]                memAddr;
    logic [1:0]                 memSize;
    logic                       memWrite;
    logic [31:0]                memWdata;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic                       traceExc;
  } csda_regs_t;

  localparam csda_regs_t REGS_RESET = '{
    state:   ST_BOOT,
    trace:   TRACE_RESET,
    mask:    MASK_RESET,
    cond:    COND_RESET,
    default: '0
  };

  csda_regs_t  s_reg;
  csda_regs_t  s_next;
  logic [1:0]  pieceSize;
  logic [1:0]  pieceOff;
  logic [1:0]  pieceCnt;
  logic [7:0]  opRes;
  logic        opZero;
  logic        opCarry;
  logic        opUpdZ;
  logic        opUpdC;
  logic        opInvalid;
  logic        apbSetup;
  logic        apbWr;
  logic [31:0] rdVal;
  logic        mapped;
  logic [2:0]  pieceBytes;
  logic [2:0]  totBytes;
  logic [2:0]  remBytes;
  logic [31:0] pieceMask;
  logic [31:0] asmNext;
  logic [1:0]  cmdSize;
  logic [1:0]  cmdStack;
  logic [2:0]  cmdBytes;

  csda_access_split u_split (
    .startLow  (s_reg.xAddr[1:0]),
    .accSize   (s_reg.xSize),
    .pieceIdx  (s_reg.pieceIdx),
    .pieceSize (pieceSize),
    .pieceOff  (pieceOff),
    .pieceCnt  (pieceCnt)
  );

  csda_op_unit u_op (
    .opCode    (csda_op_t'(pwdata[OPC_CODE_LSB +: 3])),
    .bitSel    (pwdata[OPC_BIT_LSB +: 3]),
    .operand   (pwdata[OPC_DATA_LSB +: 8]),
    .carryIn   (s_reg.cond[COND_C_POS]),
    .halfIn    (s_reg.cond[COND_H_POS]),
    .result    (opRes),
    .zeroOut   (opZero),
    .carryOut  (opCarry),
    .updZero   (opUpdZ),
    .updCarry  (opUpdC),
    .invalidOp (opInvalid)
  );

  always_comb begin
    s_next     = s_reg;
    s_next.traceExc = 1'b0;
    apbSetup   = psel && !penable;
    apbWr      = psel && penable && s_reg.pready && pwrite;
    cmdSize    = pwdata[CMD_SIZE_LSB +: 2];
    cmdStack   = pwdata[CMD_STACK_LSB +: 2];
    cmdBytes   = 3'h1 << cmdSize;
    pieceBytes = 3'h1 << pieceSize;
    totBytes   = 3'h1 << s_reg.xSize;
    remBytes   = 3'(totBytes - {1'b0, pieceOff} - pieceBytes);
    case (pieceSize)
      SIZE_BYTE: pieceMask = 32'h000000ff;
      SIZE_WORD: pieceMask = 32'h0000ffff;
      default:   pieceMask = 32'hffffffff;
    endcase
    asmNext = (s_reg.asm << {pieceBytes, 3'h0}) | (memRdata & pieceMask);

    // Register read mux
    mapped = 1'b1;
    case (paddr)
      OFF_ACC_HIGH:  rdVal = {{(32 - ACC_HIGH_BITS){s_reg.accHigh[ACC_HIGH_BITS-1]}}, s_reg.accHigh};
      OFF_ACC_LOW:   rdVal = s_reg.accLow;
      OFF_EXT_CTRL:  rdVal = {24'h0, s_reg.trace, EXT_RSVD_VALUE, s_reg.mask};
      OFF_COND_CODE: rdVal = {24'h0, s_reg.cond};
      OFF_STACK_PTR: rdVal = s_reg.sp;
      OFF_PROG_CNT:  rdVal = s_reg.pc;
      OFF_STATUS:    rdVal = {28'h0, s_reg.errOp, s_reg.errAlign, s_reg.state != ST_IDLE, s_reg.bootDone};
      OFF_XFER_ADDR: rdVal = s_reg.xAddr;
      OFF_XFER_DATA: rdVal = s_reg.xData;
      OFF_XFER_CMD:  rdVal = {26'h0, s_reg.xStack, 1'b0, s_reg.xWrite, s_reg.xSize};
      OFF_OP_RESULT: rdVal = {24'h0, s_reg.opResult};
      OFF_INFO:      rdVal = {8'h0, TYPES_SHIFT, TYPES_ARITH, TYPES_TOTAL};
      default: begin
        rdVal  = 32'h00000000;
        mapped = 1'b0;
      end
    endcase

    // APB answer, one access cycle after setup
    s_next.pready = apbSetup;
    if (apbSetup) begin
      s_next.prdata  = rdVal;
      s_next.pslverr = !mapped;
    end

    // Register writes
    if (apbWr) begin
      case (paddr)
        OFF_ACC_HIGH: s_next.accHigh = pwdata[ACC_HIGH_BITS-1:0];
        OFF_ACC_LOW:  s_next.accLow  = pwdata;
        OFF_EXT_CTRL: begin
          s_next.trace = pwdata[EXT_TRACE_POS];
          s_next.mask  = pwdata[EXT_MASK_LSB +: 3];
        end
        OFF_COND_CODE: s_next.cond = pwdata[7:0];
        OFF_STACK_PTR: s_next.sp   = pwdata;
        OFF_STATUS: begin
          if (pwdata[STAT_ERR_ALIGN]) begin
            s_next.errAlign = 1'b0;
          end
          if (pwdata[STAT_ERR_OP]) begin
            s_next.errOp = 1'b0;
          end
        end
        OFF_XFER_ADDR: begin
          if (s_reg.state == ST_IDLE) begin
            s_next.xAddr = pwdata;
          end
        end
        OFF_XFER_DATA: begin
          if (s_reg.state == ST_IDLE) begin
            s_next.xData = pwdata;
          end
        end
        OFF_XFER_CMD: begin
          if (s_reg.state == ST_IDLE) begin
            if (cmdStack != STACK_NONE && (cmdSize == SIZE_BYTE || s_reg.sp[0])) begin
              s_next.errAlign = 1'b1;
            end else if (cmdSize == 2'h3 || cmdStack == 2'h3) begin
              s_next.errOp = 1'b1;
            end else begin
              s_next.xSize    = cmdSize;
              s_next.xStack   = cmdStack;
              s_next.xWrite   = (cmdStack == STACK_PUSH) || (cmdStack == STACK_NONE && pwdata[CMD_WRITE_POS]);
              s_next.pieceIdx = 2'h0;
              s_next.asm      = 32'h00000000;
              s_next.state    = ST_ISSUE;
              if (cmdStack == STACK_PUSH) begin
                s_next.sp    = s_reg.sp - {29'h0, cmdBytes};
                s_next.xAddr = s_reg.sp - {29'h0, cmdBytes};
              end else if (cmdStack == STACK_POP) begin
                s_next.xAddr = s_reg.sp;
              end
            end
          end
        end
        OFF_OP_CTRL: begin
          if (opInvalid) begin
            s_next.errOp = 1'b1;
          end else begin
            s_next.opResult = opRes;
            if (opUpdZ) begin
              s_next.cond[COND_Z_POS] = opZero;
            end
            if (opUpdC) begin
              s_next.cond[COND_C_POS] = opCarry;
            end
            s_next.traceExc = s_reg.trace;
          end
        end
        default: begin
        end
      endcase
    end

    // Bus access engine
    case (s_reg.state)
      ST_BOOT: begin
        s_next.xAddr    = VECTOR_ADDR;
        s_next.xSize    = SIZE_LONG;
        s_next.xWrite   = 1'b0;
        s_next.xStack   = STACK_NONE;
        s_next.pieceIdx = 2'h0;
        s_next.asm      = 32'h00000000;
        s_next.state    = ST_ISSUE;
      end
      ST_IDLE: begin
      end
      ST_ISSUE: begin
        s_next.memReq   = 1'b1;
        s_next.memAddr  = s_reg.xAddr + {30'h0, pieceOff};
        s_next.memSize  = pieceSize;
        s_next.memWrite = s_reg.xWrite;
        s_next.memWdata = (s_reg.xData >> {remBytes, 3'h0}) & pieceMask;
        s_next.state    = ST_WAIT;
      end
      ST_WAIT: begin
        if (memAck) begin
          s_next.memReq   = 1'b0;
          s_next.memWrite = 1'b0;
          s_next.asm      = asmNext;
          if (s_reg.pieceIdx == 2'(pieceCnt - 2'h1)) begin
            s_next.state = ST_IDLE;
            if (!s_reg.bootDone) begin
              s_next.pc       = asmNext;
              s_next.bootDone = 1'b1;
            end else begin
              if (!s_reg.xWrite) begin
                s_next.xData = asmNext;
              end
              if (s_reg.xStack == STACK_POP) begin
                s_next.sp = s_reg.sp + {29'h0, totBytes};
              end
              s_next.traceExc = s_reg.trace;
            end
          end else begin
            s_next.pieceIdx = s_reg.pieceIdx + 2'h1;
            s_next.state    = ST_ISSUE;
          end
        end
      end
      default: s_next.state = ST_IDLE;
    endcase
  end

  // All state is forced at reset; data contents are cleared to zero, mask loads MASK_RESET, cond loads COND_RESET
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= REGS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata       = s_reg.prdata;
  assign pready       = s_reg.pready;
  assign pslverr      = s_reg.pslverr;
  assign memReq       = s_reg.memReq;
  assign memAddr      = s_reg.memAddr;
  assign memSize      = s_reg.memSize;
  assign memWrite     = s_reg.memWrite;
  assign memWdata     = s_reg.memWdata;
  assign traceExc     = s_reg.traceExc;
  assign intMaskLevel = s_reg.mask;

endmodule

//--- verif/csda_monitor.sv
// Purpose: Concurrent checks on the csda_core ports
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound from tb
`timescale 1ns/1ps
module csda_monitor #(
  parameter logic [31:0] VECTOR_ADDR = 32'h00000000
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // APB
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Memory bus
  input wire logic        memReq,
  input wire logic [31:0] memAddr,
  input wire logic [1:0]  memSize,
  input wire logic        memAck,
  // Status
  input wire logic        traceExc,
  input wire logic [2:0]  intMaskLevel
);
  import csda_pkg::*;
  logic traceOn_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence apbRd(logic [7:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  sequence apbWr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  sequence pieceHeld;
    memReq && !memAck;
  endsequence
  // Trace bit as last written
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) traceOn_reg <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == OFF_EXT_CTRL) traceOn_reg <= pwdata[7];
  end
  a_boot_fetch: assert property ($fell(rst) |-> ##[1:3] memReq && memAddr == VECTOR_ADDR && memSize == 2'h2)
    else $error("no vector fetch");
  a_reset_mask: assert property (disable iff (1'b0) rst |-> intMaskLevel == 3'h7 && !traceExc)
    else $error("mask not set in reset");
  a_high_sext: assert property (apbRd(OFF_ACC_HIGH) |-> prdata[31:10] == {22{prdata[9]}})
    else $error("high half not extended");
  a_ext_read: assert property (apbRd(OFF_EXT_CTRL) |-> prdata == {24'h0, traceOn_reg, 4'hf, intMaskLevel})
    else $error("bad ext readback");
  a_mask_write: assert property (apbWr(OFF_EXT_CTRL) |=> {29'h0, intMaskLevel} == ($past(pwdata) & 32'h7))
    else $error("mask level not updated");
  a_info_count: assert property (apbRd(OFF_INFO) |-> prdata == 32'h00081b57)
    else $error("inventory figures wrong");
  a_trace_off: assert property (!traceOn_reg && !$past(traceOn_reg) |-> !traceExc)
    else $error("trace event while trace off");
  a_piece_hold: assert property (pieceHeld |=> memReq && $stable(memAddr) && $stable(memSize))
    else $error("piece dropped before ack");
  a_piece_gap: assert property (memReq && memAck |=> !memReq)
    else $error("no gap after piece");
  a_piece_align: assert property (memReq |-> memSize != 2'h3 && (memSize != SIZE_WORD || !memAddr[0]) &&
                                  (memSize != SIZE_LONG || memAddr[1:0] == 2'h0))
    else $error("misaligned piece issued");
endmodule

//--- verif/csda_mem_model.sv
// Purpose: Byte memory answering the core's bus pieces
// Assumes: Big-endian, right-justified piece data
// Notes:   Ack delay from waitCyc; idle read data toggles
`timescale 1ns/1ps
module csda_mem_model (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Bus from the core
  input wire logic        memReq,
  input wire logic [31:0] memAddr,
  input wire logic [1:0]  memSize,
  input wire logic        memWrite,
  input wire logic [31:0] memWdata,
  input wire logic [1:0]  waitCyc,
  // Answer
  output logic            memAck,
  output logic     [31:0] memRdata
);
  logic [7:0] mem [256];
  logic [1:0] cnt;
  logic [7:0] a;
  logic [2:0] n;
  assign a = memAddr[7:0];
  assign n = memSize == 2'h0 ? 3'h1 : memSize == 2'h1 ? 3'h2 : 3'h4;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      memAck   <= 1'b0;
      cnt      <= 2'h0;
      memRdata <= 32'h0;
    end else begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata;
      if (!memReq || memAck) cnt <= 2'h0;
      else if (cnt != waitCyc) cnt <= cnt + 2'h1;
      else begin
        memAck <= 1'b1;
        memRdata <= {mem[a], mem[a + 8'h1], mem[a + 8'h2], mem[a + 8'h3]} >> (8 * (4 - n));
        for (int i = 0; i < 4; i++)
          if (memWrite && i < n) mem[a + 8'(i)] <= memWdata[8 * (n - 1 - i) +: 8];
      end
    end
  end
endmodule

//--- verif/tb.sv
// Purpose: Self-checking bench for csda_core over APB
// Assumes: 10 MHz ref_clk, reset held 6 cycles
// Notes:   Reads and pieces checked in issue order
`timescale 1ns/1ps
module tb;
  import csda_pkg::*;
  localparam logic [31:0] VEC = 32'h00000040;
  localparam logic [9:0]  RD_TAB [7] = '{10'h021, 10'h122, 10'h125, 10'h223, 10'h226, 10'h228, 10'h235};
  logic        ref_clk = 1'b0;
  logic        rst = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [1:0]  waitCyc = 2'h0;
  logic [31:0] prdata, memAddr, memWdata, memRdata, rdat, d;
  logic        pready, pslverr, memReq, memWrite, memAck, traceExc;
  logic [1:0]  memSize, s;
  logic [2:0]  intMaskLevel;
  logic [7:0]  a8, e8;
  logic [32:0] eV, mV, expQ[$], mskQ[$];
  logic [10:0] pieceQ[$];
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          nTrace = 0;
  int          t0;
  always #50 ref_clk = ~ref_clk;
  csda_core #(.VECTOR_ADDR(VEC)) dut_u (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memReq(memReq), .memAddr(memAddr), .memSize(memSize), .memWrite(memWrite), .memWdata(memWdata),
    .memAck(memAck), .memRdata(memRdata), .traceExc(traceExc), .intMaskLevel(intMaskLevel));
  csda_mem_model mem_u (.ref_clk(ref_clk), .rst(rst), .memReq(memReq), .memAddr(memAddr), .memSize(memSize),
    .memWrite(memWrite), .memWdata(memWdata), .waitCyc(waitCyc), .memAck(memAck), .memRdata(memRdata));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= dt;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pc(input logic [1:0] sz, input logic w, input logic [7:0] a);
    pieceQ.push_back({sz, w, a});
  endtask
  task automatic xfer(input logic [1:0] sz, input logic w, input logic [1:0] stk, input logic [7:0] a,
                      input logic [31:0] dt);
    waitCyc <= 2'($urandom);
    apb(1'b1, OFF_XFER_ADDR, {24'h0, a});
    apb(1'b1, OFF_XFER_DATA, dt);
    if (stk == STACK_NONE && (sz == SIZE_BYTE || (sz == SIZE_WORD && a[0]) || (sz == SIZE_LONG && a[0])))
      pc(SIZE_BYTE, w, a);
    if (stk == STACK_NONE && sz == SIZE_WORD) pc(a[0] ? SIZE_BYTE : SIZE_WORD, w, a + 8'(a[0]));
    if (stk == STACK_NONE && sz == SIZE_LONG && a[1:0] == 2'h0) pc(SIZE_LONG, w, a);
    if (stk == STACK_NONE && sz == SIZE_LONG && a[1:0] == 2'h2) pc(SIZE_WORD, w, a);
    if (stk == STACK_NONE && sz == SIZE_LONG && a[1:0] != 2'h0) pc(SIZE_WORD, w, a + 8'(a[0] ? 1 : 2));
    if (stk == STACK_NONE && sz == SIZE_LONG && a[0]) pc(SIZE_BYTE, w, a + 8'h3);
    apb(1'b1, OFF_XFER_CMD, {26'h0, stk, 1'b0, w, sz});
    do rd(OFF_STATUS, 33'h0, 33'h0); while (rdat[STAT_BUSY] !== 1'b0);
  endtask
  function automatic logic [31:0] beval(input logic [7:0] a, input logic [1:0] sz);
    logic [31:0] v;
    v = {a, a + 8'h1, a + 8'h2, a + 8'h3} ^ 32'h5a5a5a5a;
    return sz == SIZE_BYTE ? v >> 24 : sz == SIZE_WORD ? v >> 16 : v;
  endfunction
  // Scoreboard side
  always @(posedge ref_clk) begin
    cyc++;
    if (traceExc === 1'b1) nTrace++;
    if (psel && penable && pready === 1'b1 && !pwrite && mskQ.size() > 0) begin
      mV = mskQ.pop_front();
      eV = expQ.pop_front();
      if (mV != 33'h0) check({pslverr, prdata} & mV, eV & mV);
    end
    if (memReq === 1'b1 && memAck === 1'b1) check({memSize, memWrite, memAddr[7:0]}, pieceQ.pop_front());
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    rst <= 1'b1;
    void'($urandom(60726));
    foreach (mem_u.mem[i]) mem_u.mem[i] = 8'(i) ^ 8'h5a;
    pc(SIZE_LONG, 1'b0, VEC[7:0]);
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b1, OFF_STACK_PTR, 32'h80);
    do rd(OFF_STATUS, 33'h0, 33'h0); while (rdat[STAT_BOOT_DONE] !== 1'b1);
    rd(OFF_PROG_CNT, {1'b0, beval(VEC[7:0], SIZE_LONG)}, '1);
    rd(OFF_EXT_CTRL, 33'h7f, '1);
    rd(OFF_COND_CODE, 33'h80, 33'h80);
    rd(OFF_INFO, 33'h00081b57, '1);
    rd(8'h40, {1'b1, 32'h0}, '1);
    for (int i = 0; i < 6; i++) begin
      d = i == 0 ? 32'h200 : i == 1 ? 32'h1ff : $urandom;
      apb(1'b1, OFF_ACC_HIGH, d);
      apb(1'b1, OFF_ACC_LOW, ~d);
      rd(OFF_ACC_HIGH, {1'b0, {22{d[9]}}, d[9:0]}, '1);
      rd(OFF_ACC_LOW, {1'b0, ~d}, '1);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFF_EXT_CTRL, 32'h78 | i);
      rd(OFF_EXT_CTRL, 33'h78 | i, '1);
    end
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      apb(1'b1, OFF_OP_CTRL, {8'h0, d[7:0], 5'h0, d[10:8], 5'h0, 3'(i)});
      e8 = i == 0 ? d[7:0] | (8'h1 << d[10:8]) : i == 1 ? d[7:0] & ~(8'h1 << d[10:8]) : d[7:0] ^ (8'h1 << d[10:8]);
      rd(OFF_OP_RESULT, {25'h0, e8}, '1);
    end
    apb(1'b1, OFF_OP_CTRL, {8'h0, 8'h80, 5'h0, 3'h6, 5'h0, 3'h3});
    rd(OFF_COND_CODE, 33'h4, 33'h4);
    apb(1'b1, OFF_COND_CODE, 32'h80);
    apb(1'b1, OFF_OP_CTRL, {8'h0, 8'h9a, 13'h0, 3'h4});
    rd(OFF_OP_RESULT, 33'h0, '1);
    rd(OFF_COND_CODE, 33'h5, 33'h5);
    apb(1'b1, OFF_COND_CODE, 32'h80);
    apb(1'b1, OFF_OP_CTRL, {8'h0, 8'h45, 13'h0, 3'h5});
    rd(OFF_OP_RESULT, 33'h45, '1);
    for (int i = 6; i < 8; i++) begin
      apb(1'b1, OFF_OP_CTRL, 32'h00ff0000 | i);
      rd(OFF_STATUS, 33'h8, 33'h8);
      apb(1'b1, OFF_STATUS, 32'h8);
    end
    apb(1'b1, OFF_EXT_CTRL, 32'hff);
    t0 = nTrace;
    apb(1'b1, OFF_OP_CTRL, 32'h0);
    @(posedge ref_clk);
    check(33'(nTrace - t0), 33'h1);
    apb(1'b1, OFF_EXT_CTRL, 32'h7f);
    foreach (RD_TAB[i]) begin
      xfer(RD_TAB[i][9:8], 1'b0, STACK_NONE, RD_TAB[i][7:0], 32'h0);
      rd(OFF_XFER_DATA, {1'b0, beval(RD_TAB[i][7:0], RD_TAB[i][9:8])}, '1);
    end
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      a8 = 8'hc0 + 8'(i * 5);
      xfer(SIZE_LONG, 1'b1, STACK_NONE, a8, d);
      check({mem_u.mem[a8], mem_u.mem[a8 + 8'h1], mem_u.mem[a8 + 8'h2], mem_u.mem[a8 + 8'h3]}, d);
    end
    xfer(SIZE_WORD, 1'b1, STACK_NONE, 8'hd1, d);
    check({mem_u.mem[8'hd1], mem_u.mem[8'hd2]}, d[15:0]);
    pc(SIZE_LONG, 1'b1, 8'h7c);
    xfer(SIZE_LONG, 1'b1, STACK_PUSH, 8'h0, d);
    rd(OFF_STACK_PTR, 33'h7c, '1);
    pc(SIZE_LONG, 1'b0, 8'h7c);
    xfer(SIZE_LONG, 1'b0, STACK_POP, 8'h0, 32'h0);
    rd(OFF_STACK_PTR, 33'h80, '1);
    rd(OFF_XFER_DATA, {1'b0, d}, '1);
    xfer(SIZE_BYTE, 1'b1, STACK_PUSH, 8'h0, d);
    rd(OFF_STATUS, 33'h4, 33'h4);
    apb(1'b1, OFF_STATUS, 32'h4);
    apb(1'b1, OFF_STACK_PTR, 32'h81);
    xfer(SIZE_WORD, 1'b1, STACK_PUSH, 8'h0, d);
    rd(OFF_STATUS, 33'h4, 33'h4);
    stop_test();
  end
endmodule
bind csda_core csda_monitor #(.VECTOR_ADDR(VECTOR_ADDR)) mon_u (.ref_clk(ref_clk), .rst(rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .memReq(memReq), .memAddr(memAddr), .memSize(memSize), .memAck(memAck), .traceExc(traceExc),
  .intMaskLevel(intMaskLevel));
